// File: asc_pkg.sv
// Overview of operation
// - write only while select, strobe, lane low
// - data stable 5 ns before write end
// - address valid before and after write
// - strobes low at least 7 ns
// - strobe-only write lasts turnoff plus setup
// - never drive bus while memory drives
// - write strobe stays high during reads
// - address valid before chip select falls; reads change address and select on one edge
// - wait 100 us after reset before access
// - wait 10 ns after leaving retention
// - deselect chip before retention entry
package asc_pkg;
   localparam int unsigned CLK_PERIOD_PS           = 4000;
   localparam int unsigned ADDR_W                  = 20;
   localparam int unsigned DATA_W                  = 16;
   localparam int unsigned POWER_TO_FIRST_ACCESS_NS = 100000;
   localparam int unsigned WRITE_DATA_SETUP_PS     = 5000;
   localparam int unsigned WRITE_STROBE_TURNOFF_PS = 5000;
   localparam int unsigned STROBE_LOW_PS           = 7000;
   localparam int unsigned READ_ACCESS_PS          = 10000;
   localparam int unsigned CYCLE_TIME_PS           = 10000;
   localparam int unsigned RETENTION_RECOVERY_PS   = 10000;
   localparam int unsigned DESELECT_TO_RETENTION_PS = 0;
   function automatic int unsigned cyc_min(input int unsigned ps);
      cyc_min = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      if (cyc_min < 1)
      begin
         cyc_min = 1;
      end
   endfunction
   localparam int unsigned POWER_CYC     = cyc_min(POWER_TO_FIRST_ACCESS_NS * 1000);
   localparam int unsigned WR_PULSE_CYC  =
      cyc_min(WRITE_STROBE_TURNOFF_PS + WRITE_DATA_SETUP_PS);
   // pins pass two flops, so the sample waits two more cycles
   localparam int unsigned SYNC_STAGES   = 2;
   localparam int unsigned RD_CYC        = cyc_min(READ_ACCESS_PS) + SYNC_STAGES;
   localparam int unsigned GAP_CYC       = 1;
   localparam int unsigned REC_CYC       = cyc_min(RETENTION_RECOVERY_PS);
   localparam int unsigned DESEL_CYC     = cyc_min(DESELECT_TO_RETENTION_PS);
   localparam int unsigned CNT_W         = 16;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
   typedef enum {ASC_POWER, ASC_IDLE, ASC_WSETUP, ASC_WPULSE, ASC_WHOLD,
      ASC_READ, ASC_GAP, ASC_RET_ENTER, ASC_RETAIN, ASC_RECOVER} asc_state_e;
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [1:0]        lane;
   } asc_req_s;
   typedef struct packed {
      logic              chip_sel_n;
      logic              write_n;
      logic              out_en_n;
      logic              low_byte_lane_n;
      logic              high_byte_lane_n;
   } asc_strobe_s;
   localparam asc_strobe_s STROBE_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage

// File: asc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module asc_ctrl
   import asc_pkg::*;
#(
   parameter int unsigned POWER_WAIT_CYC = POWER_CYC
)
(
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic              req_valid,
   input  wire asc_req_s          req,
   output logic                   req_ready,
   output logic                   rd_valid,
   output logic [DATA_W-1:0]      rd_data,
   input  wire logic              retain_req,
   output logic                   retain_active,
   output logic [ADDR_W-1:0]      mem_addr,
   output asc_strobe_s            mem_strobe,
   input  wire logic [DATA_W-1:0] mem_data_in,
   output logic [DATA_W-1:0]      mem_data_out,
   output logic                   mem_data_oe
);
   asc_state_e        state_reg,  state_next;
   logic [CNT_W-1:0]  cnt_reg,    cnt_next;
   asc_req_s          cur_reg,    cur_next;
   asc_strobe_s       strobe_reg, strobe_next;
   logic              oe_reg,     oe_next;
   logic              ready_reg,  ready_next;
   logic              rdv_reg,    rdv_next;
   logic [DATA_W-1:0] rdat_reg,   rdat_next;
   logic              ret_reg,    ret_next;
   logic [DATA_W-1:0] din_meta_reg, din_sync_reg;

   function automatic logic [CNT_W-1:0] cnt_of(input int unsigned c);
      cnt_of = CNT_W'(c - 1);
   endfunction

   // data pins pass two flops before use
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         din_meta_reg <= '0;
         din_sync_reg <= '0;
      end
      else
      begin
         din_meta_reg <= mem_data_in;
         din_sync_reg <= din_meta_reg;
      end
   end

   always_comb
   begin
      state_next  = state_reg;
      cnt_next    = (cnt_reg == CNT_ZERO) ? CNT_ZERO : cnt_reg - CNT_ONE;
      cur_next    = cur_reg;
      strobe_next = strobe_reg;
      oe_next     = oe_reg;
      ready_next  = 1'b0;
      rdv_next    = 1'b0;
      rdat_next   = rdat_reg;
      ret_next    = ret_reg;
      unique case (state_reg)
         ASC_POWER:
         begin
            if (cnt_reg == CNT_ZERO)
            begin
               state_next = ASC_IDLE;
               ready_next = 1'b1;
            end
         end
         ASC_IDLE:
         begin
            ready_next = 1'b1;
            if (retain_req)
            begin
               // chip already deselected in idle
               strobe_next = STROBE_IDLE;
               state_next  = ASC_RET_ENTER;
               cnt_next    = cnt_of(DESEL_CYC);
               ready_next  = 1'b0;
            end
            else if (req_valid && ready_reg)
            begin
               cur_next   = req;
               ready_next = 1'b0;
               if (req.write)
               begin
                  // address and data set up, drive on, before any strobe
                  oe_next    = 1'b1;
                  state_next = ASC_WSETUP;
               end
               else
               begin
                  strobe_next.chip_sel_n       = 1'b0;
                  strobe_next.out_en_n         = 1'b0;
                  strobe_next.write_n          = 1'b1;
                  strobe_next.low_byte_lane_n  = ~req.lane[0];
                  strobe_next.high_byte_lane_n = ~req.lane[1];
                  state_next = ASC_READ;
                  cnt_next   = cnt_of(RD_CYC);
               end
            end
         end
         ASC_WSETUP:
         begin
            strobe_next.chip_sel_n       = 1'b0;
            strobe_next.write_n          = 1'b0;
            strobe_next.low_byte_lane_n  = ~cur_reg.lane[0];
            strobe_next.high_byte_lane_n = ~cur_reg.lane[1];
            state_next = ASC_WPULSE;
            cnt_next   = cnt_of(WR_PULSE_CYC);
         end
         ASC_WPULSE:
         begin
            if (cnt_reg == CNT_ZERO)
            begin
               strobe_next = STROBE_IDLE;
               state_next  = ASC_WHOLD;
            end
         end
         ASC_WHOLD:
         begin
            // data and address held one cycle past the write end
            oe_next    = 1'b0;
            state_next = ASC_GAP;
            cnt_next   = cnt_of(GAP_CYC);
         end
         ASC_READ:
         begin
            if (cnt_reg == CNT_ZERO)
            begin
               rdat_next   = din_sync_reg;
               rdv_next    = 1'b1;
               strobe_next = STROBE_IDLE;
               state_next  = ASC_GAP;
               cnt_next    = cnt_of(GAP_CYC);
            end
         end
         ASC_GAP:
         begin
            if (cnt_reg == CNT_ZERO)
            begin
               state_next = ASC_IDLE;
               ready_next = 1'b1;
            end
         end
         ASC_RET_ENTER:
         begin
            if (cnt_reg == CNT_ZERO)
            begin
               ret_next   = 1'b1;
               state_next = ASC_RETAIN;
            end
         end
         ASC_RETAIN:
         begin
            if (!retain_req)
            begin
               ret_next   = 1'b0;
               state_next = ASC_RECOVER;
               cnt_next   = cnt_of(REC_CYC);
            end
         end
         ASC_RECOVER:
         begin
            if (cnt_reg == CNT_ZERO)
            begin
               state_next = ASC_IDLE;
               ready_next = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg  <= ASC_POWER;
         cnt_reg    <= cnt_of(POWER_WAIT_CYC);
         cur_reg    <= '0;
         strobe_reg <= STROBE_IDLE;
         oe_reg     <= 1'b0;
         ready_reg  <= 1'b0;
         rdv_reg    <= 1'b0;
         rdat_reg   <= '0;
         ret_reg    <= 1'b0;
      end
      else
      begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         cur_reg    <= cur_next;
         strobe_reg <= strobe_next;
         oe_reg     <= oe_next;
         ready_reg  <= ready_next;
         rdv_reg    <= rdv_next;
         rdat_reg   <= rdat_next;
         ret_reg    <= ret_next;
      end
   end

   assign req_ready     = ready_reg;
   assign rd_valid      = rdv_reg;
   assign rd_data       = rdat_reg;
   assign retain_active = ret_reg;
   assign mem_addr      = cur_reg.addr;
   assign mem_strobe    = strobe_reg;
   assign mem_data_out  = cur_reg.wdata;
   assign mem_data_oe   = oe_reg;

   sequence s_write_start;
      !strobe_reg.write_n && !strobe_reg.chip_sel_n;
   endsequence
   sequence s_write_pulse;
      s_write_start [*3];
   endsequence

   AST_WRITE_NEEDS_LANE: assert property (@(posedge sys_clk) disable iff (reset)
      !strobe_reg.write_n |-> !strobe_reg.chip_sel_n &&
      (!strobe_reg.low_byte_lane_n || !strobe_reg.high_byte_lane_n))
      else $error("write strobe without select or lane");
   AST_DATA_SETUP: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(strobe_reg.write_n) |-> oe_reg && $stable(mem_data_out))
      else $error("write data not held at write end");
   AST_ADDR_SETUP: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(strobe_reg.write_n) |-> $stable(mem_addr) && $past(oe_reg))
      else $error("address or data not set up before write");
   AST_PULSE_WIDTH: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(strobe_reg.write_n) |-> s_write_pulse)
      else $error("write pulse shorter than minimum");
   AST_PULSE_OE: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(strobe_reg.write_n) |-> strobe_reg.out_en_n [*3])
      else $error("output drive enabled during write pulse");
   AST_NO_CONTENTION: assert property (@(posedge sys_clk) disable iff (reset)
      mem_data_oe |-> strobe_reg.out_en_n)
      else $error("bus driven while memory drives");
   AST_READ_WRITE_HIGH: assert property (@(posedge sys_clk) disable iff (reset)
      !strobe_reg.out_en_n |-> strobe_reg.write_n)
      else $error("write strobe low during read");
   AST_ADDR_AT_SELECT: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(strobe_reg.chip_sel_n) |=> $stable(mem_addr))
      else $error("address changed after select");
   AST_POWER_WAIT: assert property (@(posedge sys_clk) disable iff (reset)
      state_reg == ASC_POWER |-> mem_strobe.chip_sel_n)
      else $error("access during power wait");
   AST_RECOVERY: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(ret_reg) |-> mem_strobe.chip_sel_n [*3])
      else $error("access too soon after retention");
   AST_DESELECT_RET: assert property (@(posedge sys_clk) disable iff (reset)
      ret_reg |-> mem_strobe.chip_sel_n)
      else $error("selected during retention");
   AST_CYCLE_GAP: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(strobe_reg.chip_sel_n) |-> strobe_reg.chip_sel_n [*2])
      else $error("accesses too close together");

   // read strobes stand through access time and both sync stages
   sequence s_read_hold;
      !strobe_reg.out_en_n [*5];
   endsequence
   sequence s_lane_held;
      (!strobe_reg.low_byte_lane_n || !strobe_reg.high_byte_lane_n) [*3];
   endsequence

   AST_READ_LATENCY: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(strobe_reg.out_en_n) |-> s_read_hold ##1 (strobe_reg.out_en_n && rdv_reg))
      else $error("read data handed over at wrong time");
   AST_READ_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
      rdv_reg |=> !rdv_reg)
      else $error("read valid longer than one cycle");
   AST_READ_LANES: assert property (@(posedge sys_clk) disable iff (reset)
      !strobe_reg.out_en_n |-> strobe_reg.low_byte_lane_n == !cur_reg.lane[0]
      && strobe_reg.high_byte_lane_n == !cur_reg.lane[1])
      else $error("read lanes differ from request");
   AST_DATA_BEFORE_STROBE: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(strobe_reg.write_n) |-> $stable(mem_data_out))
      else $error("write data changed at write start");
   AST_PULSE_END: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(strobe_reg.write_n) |-> ##3 strobe_reg.write_n)
      else $error("write pulse not ended");
   AST_LANES_HELD: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(strobe_reg.write_n) |-> s_lane_held)
      else $error("byte lane released early in write");
   AST_DRIVE_ON: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(oe_reg) |-> strobe_reg.out_en_n && strobe_reg.chip_sel_n)
      else $error("drive started while memory selected");
   AST_DRIVE_OFF: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(oe_reg) |-> strobe_reg.write_n && strobe_reg.chip_sel_n)
      else $error("drive released inside write");
   AST_POWER_READY: assert property (@(posedge sys_clk) disable iff (reset)
      state_reg == ASC_POWER |-> !ready_reg)
      else $error("ready during power wait");
   AST_READY_IDLE: assert property (@(posedge sys_clk) disable iff (reset)
      ready_reg |-> strobe_reg.chip_sel_n && !oe_reg)
      else $error("ready while access in flight");
   AST_RETAIN_ENTRY: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(ret_reg) |-> $past(strobe_reg.chip_sel_n))
      else $error("retention entered while selected");
endmodule
`default_nettype wire

// File: asc_sram_model.sv
`timescale 1ns/1ns
`default_nettype none
module asc_sram_model
   import asc_pkg::*;
#(
   parameter int unsigned RD_DLY = 10
)
(
   input  wire logic [ADDR_W-1:0] mem_addr,
   input  wire asc_strobe_s       mem_strobe,
   input  wire logic [DATA_W-1:0] mem_data_out,
   input  wire logic              mem_data_oe,
   output logic [DATA_W-1:0]      mem_data_in,
   output logic                   clash
);
   logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] word;
   logic [DATA_W-1:0] wword;
   logic [DATA_W-1:0] last;
   logic [DATA_W-1:0] pins;
   logic [1:0]        rd_lane;
   asc_strobe_s       prev;
   logic              was_wr;
   initial
   begin
      prev = STROBE_IDLE;
      last = 16'h0000;
      clash = 1'b0;
   end
   // write ends at first rising edge of select or write strobe
   always @(mem_strobe)
   begin
      was_wr = !prev.chip_sel_n && !prev.write_n;
      wword = store[mem_addr];
      if (was_wr && !(mem_strobe.chip_sel_n == 1'b0 && mem_strobe.write_n == 1'b0))
      begin
         if (!prev.low_byte_lane_n) wword[7:0] = mem_data_out[7:0];
         if (!prev.high_byte_lane_n) wword[15:8] = mem_data_out[15:8];
         store[mem_addr] = wword;
      end
      prev = mem_strobe;
   end
   // lanes float unless selected, enabled and not writing
   always @(mem_strobe or mem_addr or mem_data_oe)
   begin
      rd_lane[0] = !mem_strobe.chip_sel_n && !mem_strobe.out_en_n && mem_strobe.write_n
         && !mem_strobe.low_byte_lane_n;
      rd_lane[1] = !mem_strobe.chip_sel_n && !mem_strobe.out_en_n && mem_strobe.write_n
         && !mem_strobe.high_byte_lane_n;
      word = store[mem_addr];
      pins[7:0] = rd_lane[0] ? word[7:0] : ~last[7:0];
      pins[15:8] = rd_lane[1] ? word[15:8] : ~last[15:8];
      if (rd_lane != 2'b00)
         last = word;
      if (rd_lane != 2'b00 && mem_data_oe === 1'b1)
         clash = 1'b1;
   end
   assign #(RD_DLY) mem_data_in = pins;
endmodule
`default_nettype wire

// File: async_sram_bus_timing_tb.sv
`timescale 1ns/1ns
`default_nettype none
module async_sram_bus_timing_tb
   import asc_pkg::*;
;
   typedef struct packed {logic [15:0] d; logic [15:0] m;} asc_exp_s;
   logic sys_clk, reset, req_valid, req_ready, rd_valid, retain_req, retain_active;
   logic mem_data_oe, clash;
   asc_req_s          req;
   asc_strobe_s       mem_strobe;
   logic [ADDR_W-1:0] mem_addr;
   logic [15:0]       rd_data, mem_data_in, mem_data_out;
   logic [31:0]       seed;
   logic [19:0]       adr [8];
   logic [15:0]       shadow [8];
   asc_exp_s          expq[$];
   asc_exp_s          e;
   int                n_errors, checked;
   localparam int unsigned PW = 20;
   asc_ctrl #(.POWER_WAIT_CYC(PW)) i_asc_ctrl (.sys_clk(sys_clk), .reset(reset),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
      .rd_data(rd_data), .retain_req(retain_req), .retain_active(retain_active),
      .mem_addr(mem_addr), .mem_strobe(mem_strobe), .mem_data_in(mem_data_in),
      .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
   asc_sram_model i_asc_sram_model (.mem_addr(mem_addr), .mem_strobe(mem_strobe),
      .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in),
      .clash(clash));
   always #2 sys_clk = ~sys_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cmp(input string nm, input logic [15:0] ex, input logic [15:0] g);
      checked++;
      if (g !== ex)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
      end
   endtask
   task automatic conclude;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one access; held until taken, expectation noted at take
   task automatic acc(input logic w, input int i, input logic [15:0] d, input logic [1:0] l);
      int n;
      logic [15:0] m;
      n = 0;
      m = {{8{l[1]}}, {8{l[0]}}};
      req_valid <= 1'b1;
      req <= '{w, adr[i], d, l};
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (req_ready !== 1'b1 && n < 200);
      if (n >= 200)
         n_errors++;
      req_valid <= 1'b0;
      if (w)
         shadow[i] = (shadow[i] & ~m) | (d & m);
      else
         expq.push_back('{shadow[i] & m, m});
      @(posedge sys_clk);
   endtask
   always @(posedge sys_clk)
   begin
      if (rd_valid === 1'b1)
      begin
         e = expq.size() > 0 ? expq.pop_front() : '{16'hdead, 16'hffff};
         cmp("rd_data", e.d, rd_data & e.m);
      end
   end
   initial
   begin
      sys_clk = 1'b0;
      reset = 1'b1;
      req_valid = 1'b0;
      req = '0;
      retain_req = 1'b0;
      seed = 32'h36f5;
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (PW) @(posedge sys_clk);
      cmp("ready_early", 16'h0000, {15'h0000, req_ready});
      @(posedge sys_clk);
      cmp("ready_power", 16'h0001, {15'h0000, req_ready});
      $display("test power wait done");
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         adr[i] = i == 0 ? 20'h0_0000 : (i == 1 ? 20'hf_ffff : {1'b0, seed[18:3], 3'(i)});
         acc(1'b1, i, seed[31:16], 2'b11);
      end
      for (int k = 0; k < 32; k++)
      begin
         seed = xs(seed);
         acc(seed[0], int'(seed[3:1]), seed[31:16], 2'(seed[7:4] % 3) + 2'b01);
      end
      $display("test random access done");
      retain_req <= 1'b1;
      for (int n = 0; n < 20 && retain_active !== 1'b1; n++)
         @(posedge sys_clk);
      cmp("retain_on", 16'h0001, {15'h0000, retain_active});
      repeat (4)
      begin
         @(posedge sys_clk);
         cmp("retain_strobe", 16'h0001, {15'h0000, mem_strobe.chip_sel_n});
      end
      retain_req <= 1'b0;
      for (int n = 0; n < 20 && retain_active !== 1'b0; n++)
         @(posedge sys_clk);
      cmp("retain_off", 16'h0000, {15'h0000, retain_active});
      @(posedge sys_clk);
      cmp("ready_recover", 16'h0000, {15'h0000, req_ready});
      repeat (2) @(posedge sys_clk);
      cmp("ready_after_rec", 16'h0001, {15'h0000, req_ready});
      $display("test retention done");
      for (int i = 0; i < 8; i++)
         acc(1'b0, i, 16'h0000, 2'b11);
      repeat (20) @(posedge sys_clk);
      cmp("reads_left", 16'h0000, 16'(expq.size()));
      cmp("bus_clash", 16'h0000, {15'h0000, clash});
      $display("test readback done");
      conclude();
   end
   initial
   begin
      #20000;
      n_errors++;
      conclude();
   end
endmodule
`default_nettype wire
